// >>> design/mst_regs.sv
// Memory access and synchronous transfer register group of a slot switching controller.
// Assumes host accesses are synchronous to clk_in and a bit tick steps the serial highways.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Address MSB picks upstream or downstream block
// - Control memory uses highway slot, data memory PCM
// - Data memory decode follows PCM mode
// - Control memory decode follows highway mode
// - Access data register carries memory byte
// - Channel A buffer byte, bit 7 first
// - Channel B buffer byte, bit 7 first
// - Channel A receive source by select bit
// - Channel B receive source by select bit
// - Channel A transmit target by select bit
// - Transfer address codes decode like access address
// - Channel A transmit address picks port, slot
// - Select bit zero writes, one reads
module mst_regs
    import mst_pkg::*;
(
    // Clock and reset
    input  wire logic           clk_in,
    input  wire logic           rst_n_in,
    // Register port
    input  wire mst_req_t       req_in,
    output logic [7:0]          rdata_out,
    output logic                access_busy_out,
    // Interface modes
    input  wire logic [1:0]     pcm_mode_in,
    input  wire logic [1:0]     cfi_mode_in,
    // Decoded location of the last memory access
    output mst_slot_port_t      access_loc_out,
    // Serial highway timing
    input  wire logic           frame_sync_in,
    input  wire logic           bit_tick_in,
    // Serial highways
    input  wire logic [3:0]     pcm_rx_in,
    input  wire logic [7:0]     cfi_rx_in,
    output logic [3:0]          pcm_tx_out,
    output logic [3:0]          pcm_tx_act_out,
    output logic [7:0]          cfi_tx_out,
    output logic [7:0]          cfi_tx_act_out
);

    // Decode of a seven-bit port and slot code by interface and mode
    function automatic mst_slot_port_t decode_loc(input logic [6:0] code,
                                                  input logic       is_cfi,
                                                  input logic [1:0] pmode,
                                                  input logic [1:0] cmode);
        mst_slot_port_t loc;
        loc = '0;
        if (is_cfi) begin
            case (cmode)
                2'd0: begin
                    loc.port = {1'b0, code[2:1]};
                    loc.slot = {2'b00, code[6:3], code[0]};
                end
                2'd1: begin
                    loc.port = {2'b00, code[1]};
                    loc.slot = {1'b0, code[6:3], code[2], code[0]};
                end
                2'd2: begin
                    loc.slot = code;
                end
                default: begin
                    loc.port = code[3:1];
                    loc.slot = {3'b000, code[6:4], code[0]};
                end
            endcase
        end else begin
            case (pmode)
                2'd0: begin
                    loc.port = {1'b0, code[2:1]};
                    loc.slot = {2'b00, code[6:3], code[0]};
                end
                2'd2: begin
                    loc.slot = code;
                end
                default: begin
                    loc.port = {2'b00, code[2]};
                    loc.slot = {1'b0, code[6:3], code[1:0]};
                end
            endcase
        end
        return loc;
    endfunction

    // Reset release through two flip-flops
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // Memories: index is direction bit plus seven-bit code
    logic [7:0] cm_mem [MST_MEM_WORDS];
    logic [7:0] dm_mem [MST_MEM_WORDS];

    // Registers
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] addr_reg, addr_next;
    logic [7:0] mdata_reg, mdata_next;
    logic [7:0] data_a_reg, data_a_next;
    logic [7:0] data_b_reg, data_b_next;
    logic [7:0] rxa_reg, rxa_next;
    logic [7:0] rxb_reg, rxb_next;
    logic [7:0] txa_reg, txa_next;
    logic [7:0] rdata_reg, rdata_next;
    mst_state_t state_reg, state_next;
    mst_slot_port_t loc_reg, loc_next;
    logic [7:0] sh_a_reg, sh_a_next;
    logic [7:0] sh_b_reg, sh_b_next;
    logic [2:0] bit_reg, bit_next;
    logic [6:0] slot_reg, slot_next;

    // Access decode
    logic           use_cm;
    logic           do_read;
    mst_slot_port_t acc_loc;
    mst_slot_port_t loc_rxa, loc_rxb, loc_txa;
    logic           hit_rxa, hit_rxb, hit_txa;
    logic           bit_rxa, bit_rxb;
    logic           slot_end;

    always_comb begin
        use_cm  = (ctrl_reg[MST_MOC_HI:MST_MOC_LO] == MST_MOC_CM_DATA)
               || (ctrl_reg[MST_CMC_HI:0] != MST_CMC_NONE);
        do_read = ctrl_reg[MST_RWS_BIT];
        acc_loc = decode_loc(addr_reg[6:0], use_cm, pcm_mode_in, cfi_mode_in);
    end

    // Transfer address decode and slot matching
    always_comb begin
        loc_rxa  = decode_loc(rxa_reg[6:0], rxa_reg[MST_IF_SEL_BIT],
                              pcm_mode_in, cfi_mode_in);
        loc_rxb  = decode_loc(rxb_reg[6:0], rxb_reg[MST_IF_SEL_BIT],
                              pcm_mode_in, cfi_mode_in);
        loc_txa  = decode_loc(txa_reg[6:0], txa_reg[MST_IF_SEL_BIT],
                              pcm_mode_in, cfi_mode_in);
        hit_rxa  = (loc_rxa.slot == slot_reg);
        hit_rxb  = (loc_rxb.slot == slot_reg);
        hit_txa  = (loc_txa.slot == slot_reg);
        slot_end = bit_tick_in && (bit_reg == MST_LAST_BIT);
        // Receive source by interface select
        bit_rxa  = rxa_reg[MST_IF_SEL_BIT] ? cfi_rx_in[loc_rxa.port]
                                           : pcm_rx_in[loc_rxa.port[1:0]];
        bit_rxb  = rxb_reg[MST_IF_SEL_BIT] ? cfi_rx_in[loc_rxb.port]
                                           : pcm_rx_in[loc_rxb.port[1:0]];
    end

    // Next values: register writes, access engine, serial capture
    always_comb begin
        ctrl_next   = ctrl_reg;
        addr_next   = addr_reg;
        mdata_next  = mdata_reg;
        data_a_next = data_a_reg;
        data_b_next = data_b_reg;
        rxa_next    = rxa_reg;
        rxb_next    = rxb_reg;
        txa_next    = txa_reg;
        state_next  = state_reg;
        loc_next    = loc_reg;
        sh_a_next   = sh_a_reg;
        sh_b_next   = sh_b_reg;
        bit_next    = bit_reg;
        slot_next   = slot_reg;
        rdata_next  = rdata_reg;
        // Host writes
        if (req_in.wr) begin
            case (req_in.addr)
                MST_ACCESS_CONTROL_REG: begin
                    ctrl_next = req_in.wdata;
                    if (state_reg == MST_IDLE) begin
                        state_next = MST_EXEC;
                    end
                end
                MST_MEMORY_ACCESS_ADDR: addr_next   = req_in.wdata;
                MST_MEMORY_ACCESS_DATA: mdata_next  = req_in.wdata;
                MST_XFER_DATA_A:        data_a_next = req_in.wdata;
                MST_XFER_DATA_B:        data_b_next = req_in.wdata;
                MST_XFER_RX_ADDR_A:     rxa_next    = req_in.wdata;
                MST_XFER_RX_ADDR_B:     rxb_next    = req_in.wdata;
                MST_XFER_TX_ADDR_A:     txa_next    = req_in.wdata;
                default: ;
            endcase
        end
        // Host reads, answered one cycle later; unmapped reads give zero
        if (req_in.rd) begin
            case (req_in.addr)
                MST_ACCESS_CONTROL_REG: rdata_next = ctrl_reg;
                MST_MEMORY_ACCESS_ADDR: rdata_next = addr_reg;
                MST_MEMORY_ACCESS_DATA: rdata_next = mdata_reg;
                MST_XFER_DATA_A:        rdata_next = data_a_reg;
                MST_XFER_DATA_B:        rdata_next = data_b_reg;
                MST_XFER_RX_ADDR_A:     rdata_next = rxa_reg;
                MST_XFER_RX_ADDR_B:     rdata_next = rxb_reg;
                MST_XFER_TX_ADDR_A:     rdata_next = txa_reg;
                default:                rdata_next = MST_REG_RESET;
            endcase
        end
        // Access engine: one cycle to execute, one to finish
        case (state_reg)
            MST_IDLE: ;
            MST_EXEC: begin
                loc_next   = acc_loc;
                state_next = MST_FINISH;
                if (do_read) begin
                    mdata_next = use_cm ? cm_mem[addr_reg] : dm_mem[addr_reg];
                end
            end
            MST_FINISH: state_next = MST_IDLE;
            default:    state_next = MST_IDLE;
        endcase
        // Bit and slot counters of the frame
        if (frame_sync_in) begin
            bit_next  = '0;
            slot_next = '0;
        end else if (bit_tick_in) begin
            bit_next = bit_reg + 3'd1;
            if (bit_reg == MST_LAST_BIT) begin
                slot_next = slot_reg + 7'd1;
            end
        end
        // Serial capture, bit 7 arrives first; capture wins over a host write
        if (bit_tick_in && !frame_sync_in) begin
            if (hit_rxa) begin
                sh_a_next = {sh_a_reg[6:0], bit_rxa};
                if (slot_end) begin
                    data_a_next = {sh_a_reg[6:0], bit_rxa};
                end
            end
            if (hit_rxb) begin
                sh_b_next = {sh_b_reg[6:0], bit_rxb};
                if (slot_end) begin
                    data_b_next = {sh_b_reg[6:0], bit_rxb};
                end
            end
        end
    end

    // Register the state
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg   <= MST_REG_RESET;
            addr_reg   <= MST_REG_RESET;
            mdata_reg  <= MST_REG_RESET;
            data_a_reg <= MST_REG_RESET;
            data_b_reg <= MST_REG_RESET;
            rxa_reg    <= MST_REG_RESET;
            rxb_reg    <= MST_REG_RESET;
            txa_reg    <= MST_REG_RESET;
            rdata_reg  <= MST_REG_RESET;
            state_reg  <= MST_IDLE;
            loc_reg    <= '0;
            sh_a_reg   <= MST_REG_RESET;
            sh_b_reg   <= MST_REG_RESET;
            bit_reg    <= '0;
            slot_reg   <= '0;
        end else begin
            ctrl_reg   <= ctrl_next;
            addr_reg   <= addr_next;
            mdata_reg  <= mdata_next;
            data_a_reg <= data_a_next;
            data_b_reg <= data_b_next;
            rxa_reg    <= rxa_next;
            rxb_reg    <= rxb_next;
            txa_reg    <= txa_next;
            rdata_reg  <= rdata_next;
            state_reg  <= state_next;
            loc_reg    <= loc_next;
            sh_a_reg   <= sh_a_next;
            sh_b_reg   <= sh_b_next;
            bit_reg    <= bit_next;
            slot_reg   <= slot_next;
        end
    end

    // Memory writes; address MSB selects upstream or downstream half
    always_ff @(posedge clk_in) begin
        if (state_reg == MST_EXEC && !do_read) begin
            if (use_cm) begin
                cm_mem[addr_reg] <= mdata_reg;
            end else begin
                dm_mem[addr_reg] <= mdata_reg;
            end
        end
    end

    // Channel A transmit, bit 7 first, routed by interface select
    logic [3:0] pcm_tx_next, pcm_act_next;
    logic [7:0] cfi_tx_next, cfi_act_next;
    logic       tx_bit;
    always_comb begin
        pcm_tx_next  = '0;
        pcm_act_next = '0;
        cfi_tx_next  = '0;
        cfi_act_next = '0;
        tx_bit       = data_a_reg[MST_LAST_BIT - bit_reg];
        if (hit_txa) begin
            if (txa_reg[MST_IF_SEL_BIT] == MST_IF_CFI) begin
                cfi_tx_next[loc_txa.port]       = tx_bit;
                cfi_act_next[loc_txa.port]      = 1'b1;
            end else begin
                pcm_tx_next[loc_txa.port[1:0]]  = tx_bit;
                pcm_act_next[loc_txa.port[1:0]] = 1'b1;
            end
        end
    end

    // Serial outputs from flip-flops
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pcm_tx_out     <= '0;
            pcm_tx_act_out <= '0;
            cfi_tx_out     <= '0;
            cfi_tx_act_out <= '0;
        end else begin
            pcm_tx_out     <= pcm_tx_next;
            pcm_tx_act_out <= pcm_act_next;
            cfi_tx_out     <= cfi_tx_next;
            cfi_tx_act_out <= cfi_act_next;
        end
    end

    assign rdata_out       = rdata_reg;
    assign access_busy_out = (state_reg != MST_IDLE);  // Host polls this
    assign access_loc_out  = loc_reg;

    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_start;
        req_in.wr && req_in.addr == MST_ACCESS_CONTROL_REG && state_reg == MST_IDLE;
    endsequence
    sequence s_run;
        access_busy_out ##1 access_busy_out ##1 !access_busy_out;
    endsequence

    a_busy_span: assert property (s_start |=> s_run)
        else $error("Access busy not exactly two cycles");
    a_read_fetch: assert property (state_reg == MST_EXEC && do_read && !use_cm
        |=> mdata_reg == dm_mem[$past(addr_reg)])
        else $error("Read access did not load data");
    a_write_store: assert property (state_reg == MST_EXEC && !do_read && use_cm
        |=> cm_mem[$past(addr_reg)] == $past(mdata_reg))
        else $error("Write access did not store data");
    a_pcm2_noport: assert property (state_reg == MST_EXEC && !use_cm && pcm_mode_in == 2'd2
        |=> access_loc_out.port == 3'd0 && access_loc_out.slot == $past(addr_reg[6:0]))
        else $error("PCM mode 2 decode wrong");
    a_cfi3_decode: assert property (state_reg == MST_EXEC && use_cm && cfi_mode_in == 2'd3
        |=> access_loc_out.port == $past(addr_reg[3:1]))
        else $error("Control memory mode 3 port decode wrong");
    a_rx_a_load: assert property (slot_end && hit_rxa && !frame_sync_in
        |=> data_a_reg == {$past(sh_a_reg[6:0]), $past(bit_rxa)})
        else $error("Channel A receive byte not captured");
    a_rx_b_load: assert property (slot_end && hit_rxb && !frame_sync_in
        |=> data_b_reg == {$past(sh_b_reg[6:0]), $past(bit_rxb)})
        else $error("Channel B receive byte not captured");
    a_tx_route: assert property (hit_txa && txa_reg[MST_IF_SEL_BIT] == MST_IF_PCM
        |=> cfi_tx_act_out == 8'h00 && pcm_tx_act_out != 4'h0)
        else $error("Channel A transmit on wrong interface");
    a_tx_first_bit: assert property (hit_txa && bit_reg == 3'd0
        && txa_reg[MST_IF_SEL_BIT] == MST_IF_CFI
        |=> cfi_tx_out[$past(loc_txa.port)] == $past(data_a_reg[7]))
        else $error("Channel A transmit not MSB first");
    a_reg_readback: assert property (req_in.rd && req_in.addr == MST_XFER_TX_ADDR_A
        |=> rdata_out == $past(txa_reg))
        else $error("Transmit address readback wrong");

endmodule : mst_regs

`default_nettype wire

// >>> pkg/mst_pkg.sv
// Package for the memory access and synchronous transfer register group.
// Assumes an 8-bit parallel register port and serial highways stepped by a bit tick.
package mst_pkg;
    // Register byte addresses
    localparam logic [7:0] MST_ACCESS_CONTROL_REG  = 8'h00;
    localparam logic [7:0] MST_MEMORY_ACCESS_ADDR  = 8'h02;
    localparam logic [7:0] MST_MEMORY_ACCESS_DATA  = 8'h04;
    localparam logic [7:0] MST_XFER_DATA_A         = 8'h06;
    localparam logic [7:0] MST_XFER_DATA_B         = 8'h08;
    localparam logic [7:0] MST_XFER_RX_ADDR_A      = 8'h0a;
    localparam logic [7:0] MST_XFER_RX_ADDR_B      = 8'h0c;
    localparam logic [7:0] MST_XFER_TX_ADDR_A      = 8'h0e;
    // Field positions
    localparam int MST_DIR_BIT        = 7;   // Upstream/downstream select
    localparam int MST_IF_SEL_BIT     = 7;   // Interface select in transfer addresses
    localparam int MST_RWS_BIT        = 7;   // Read/write select in access control
    localparam int MST_MOC_HI         = 6;
    localparam int MST_MOC_LO         = 3;
    localparam int MST_CMC_HI         = 2;
    // Field values
    localparam logic [3:0] MST_MOC_CM_DATA   = 4'he;   // Control memory data access
    localparam logic [2:0] MST_CMC_NONE      = 3'h0;
    localparam logic       MST_IF_PCM        = 1'b0;
    localparam logic       MST_IF_CFI        = 1'b1;
    localparam logic [7:0] MST_REG_RESET     = 8'h00;
    // Timing
    localparam logic [2:0] MST_LAST_BIT      = 3'h7;   // Eighth bit of a time slot
    localparam int         MST_MEM_WORDS     = 256;
    localparam int         MST_PCM_PORTS     = 4;
    localparam int         MST_CFI_PORTS     = 8;

    // Access engine states, Gray coded along idle, execute, finish
    typedef enum logic [1:0] {
        MST_IDLE   = 2'b00,
        MST_EXEC   = 2'b01,
        MST_FINISH = 2'b11
    } mst_state_t;

    // Register port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mst_req_t;

    // Decoded port and time slot
    typedef struct packed {
        logic [2:0] port;
        logic [6:0] slot;
    } mst_slot_port_t;
endpackage : mst_pkg

// >>> verification/mst_highway_model.sv
// Far-side model of the PCM and subscriber highways: frame sync, bit ticks, receive bits.
// Assumes the bench calls run_frame while the register side is idle.
`timescale 1ns/1ps
`default_nettype none
module mst_highway_model (
    // Clock
    input  wire logic       clk_in,
    // Transmit lines from the block
    input  wire logic [3:0] pcm_tx_in,
    input  wire logic [3:0] pcm_tx_act_in,
    input  wire logic [7:0] cfi_tx_in,
    input  wire logic [7:0] cfi_tx_act_in,
    // Timing and receive lines into the block
    output logic            frame_sync_out,
    output logic            bit_tick_out,
    output logic [3:0]      pcm_rx_out,
    output logic [7:0]      cfi_rx_out
);
    // Quiet lines at time zero
    initial begin
        frame_sync_out = 1'b0;
        bit_tick_out   = 1'b0;
        pcm_rx_out     = 4'h0;
        cfi_rx_out     = 8'h00;
    end

    // One frame of eight slots: drive one receive byte, capture one transmit slot
    task automatic run_frame(input logic rx_cfi, input logic [2:0] rx_port,
                             input logic [6:0] rx_slot, input logic [7:0] rx_byte,
                             input logic tx_cfi, input logic [2:0] tx_port,
                             input logic [6:0] tx_slot, output logic [7:0] tx_byte,
                             output logic [7:0] tx_act);
        int t;
        tx_byte = 8'h00;
        tx_act  = 8'h00;
        @(posedge clk_in);
        #1 frame_sync_out = 1'b1;
        @(posedge clk_in);
        #1 frame_sync_out = 1'b0;
        for (t = 0; t < 64; t++) begin
            // Untargeted lines toggle every bit so stale data never matches
            pcm_rx_out = {4{t[0]}};
            cfi_rx_out = {8{~t[0]}};
            if (t / 8 == rx_slot) begin
                if (rx_cfi) cfi_rx_out[rx_port] = rx_byte[7 - t % 8];
                else pcm_rx_out[rx_port[1:0]] = rx_byte[7 - t % 8];
            end
            repeat (2) @(posedge clk_in);
            #1 bit_tick_out = 1'b1;
            if (t / 8 == tx_slot) begin
                tx_byte[7 - t % 8] = tx_cfi ? cfi_tx_in[tx_port] : pcm_tx_in[tx_port[1:0]];
                tx_act[7 - t % 8] = tx_cfi ? cfi_tx_act_in[tx_port]
                                           : pcm_tx_act_in[tx_port[1:0]];
            end
            @(posedge clk_in);
            #1 bit_tick_out = 1'b0;
        end
        pcm_rx_out = ~pcm_rx_out;
        cfi_rx_out = ~cfi_rx_out;
    endtask
endmodule // mst_highway_model
`default_nettype wire

// >>> verification/tb_mem_access_sync_transfer.sv
// Self-checking bench for the memory access and synchronous transfer registers.
// Assumes mst_pkg is compiled first and the highway model drives the serial side.
`timescale 1ns/1ps
`default_nettype none
module tb_mem_access_sync_transfer
    import mst_pkg::*;
;
    logic           clk_in, rst_n_in, access_busy_out, frame_sync_in, bit_tick_in;
    mst_req_t       req_in;
    logic [7:0]     rdata_out, cfi_rx_in, cfi_tx_out, cfi_tx_act_out, txb, txa;
    logic [1:0]     pcm_mode_in, cfi_mode_in;
    mst_slot_port_t access_loc_out;
    logic [3:0]     pcm_rx_in, pcm_tx_out, pcm_tx_act_out;
    int             miscompares, n_tests, i, m, c;

    // Clock, 4 ns period
    initial clk_in = 1'b0;
    always #2 clk_in = ~clk_in;

    // Block and far side
    mst_regs u_mst_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req_in),
        .rdata_out(rdata_out), .access_busy_out(access_busy_out), .pcm_mode_in(pcm_mode_in),
        .cfi_mode_in(cfi_mode_in), .access_loc_out(access_loc_out),
        .frame_sync_in(frame_sync_in), .bit_tick_in(bit_tick_in), .pcm_rx_in(pcm_rx_in),
        .cfi_rx_in(cfi_rx_in), .pcm_tx_out(pcm_tx_out), .pcm_tx_act_out(pcm_tx_act_out),
        .cfi_tx_out(cfi_tx_out), .cfi_tx_act_out(cfi_tx_act_out));
    mst_highway_model u_mst_highway_model (.clk_in(clk_in), .pcm_tx_in(pcm_tx_out),
        .pcm_tx_act_in(pcm_tx_act_out), .cfi_tx_in(cfi_tx_out), .cfi_tx_act_in(cfi_tx_act_out),
        .frame_sync_out(frame_sync_in), .bit_tick_out(bit_tick_in), .pcm_rx_out(pcm_rx_in),
        .cfi_rx_out(cfi_rx_in));

    // Compare tasks, one per kind of result
    task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check_loc(input string what, input mst_slot_port_t exp,
                             input mst_slot_port_t got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Register port cycles
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1 req_in = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_in);
        #1 req_in.wr = 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_in);
        #1 req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_in);
        #1 req_in.rd = 1'b0;
        check8(what, exp, rdata_out);
    endtask

    // Memory access: address, control, then busy for exactly two cycles
    task automatic mem_op(input logic [7:0] ctrl, input logic [7:0] a);
        reg_wr(MST_MEMORY_ACCESS_ADDR, a);
        reg_wr(MST_ACCESS_CONTROL_REG, ctrl);
        check8("busy first", 8'h01, {7'h00, access_busy_out});
        @(posedge clk_in);
        #1 check8("busy second", 8'h01, {7'h00, access_busy_out});
        @(posedge clk_in);
        #1 check8("busy cleared", 8'h00, {7'h00, access_busy_out});
    endtask

    // Expected port and slot for a seven-bit code
    function automatic mst_slot_port_t exp_loc(input int cm, input int md, input logic [6:0] a);
        mst_slot_port_t r;
        r = '0;
        if (md == 2) r.slot = a;
        else if (md == 0) begin
            r.slot = 7'({a[6:3], a[0]});
            r.port = 3'(a[2:1]);
        end else if (cm == 0) begin
            r.slot = 7'({a[6:3], a[1:0]});
            r.port = 3'(a[2]);
        end else if (md == 1) begin
            r.slot = 7'({a[6:3], a[2], a[0]});
            r.port = 3'(a[1]);
        end else begin
            r.slot = 7'({a[6:4], a[0]});
            r.port = a[3:1];
        end
        return r;
    endfunction

    // Verdict and end of run
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end

    // Test sequence
    initial begin
        miscompares = 0;
        n_tests = 0;
        rst_n_in = 1'b0;
        req_in = '0;
        pcm_mode_in = 2'd2;
        cfi_mode_in = 2'd2;
        repeat (2) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        repeat (3) @(posedge clk_in);
        // Reset values, read back, unmapped places
        for (i = 1; i < 8; i++) rd_chk(8'(2 * i), MST_REG_RESET, "reset value");
        for (i = 1; i < 8; i++) begin
            reg_wr(8'(2 * i), 8'(8'h11 * i));
            rd_chk(8'(2 * i), 8'(8'h11 * i), "register");
        end
        reg_wr(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00, "unmapped");
        $display("test registers done");
        // Address decode for every mode and both memories; writes, so no unwritten word is read
        for (m = 0; m < 4; m++) for (c = 0; c < 2; c++) begin
            pcm_mode_in = 2'(m);
            cfi_mode_in = 2'(m);
            mem_op(c ? 8'h70 : 8'h08, 8'hdb);
            check_loc("location", exp_loc(c, m, 7'h5b), access_loc_out);
        end
        $display("test decode done");
        // Write then read both directions and control memory
        pcm_mode_in = 2'd2;
        cfi_mode_in = 2'd2;
        reg_wr(MST_MEMORY_ACCESS_DATA, 8'ha5);
        mem_op(8'h08, 8'h85);
        reg_wr(MST_MEMORY_ACCESS_DATA, 8'h3c);
        mem_op(8'h08, 8'h05);
        reg_wr(MST_MEMORY_ACCESS_DATA, 8'h69);
        mem_op(8'h70, 8'h22);
        mem_op(8'h88, 8'h85);
        rd_chk(MST_MEMORY_ACCESS_DATA, 8'ha5, "upstream byte");
        mem_op(8'h88, 8'h05);
        rd_chk(MST_MEMORY_ACCESS_DATA, 8'h3c, "downstream byte");
        mem_op(8'hf0, 8'h22);
        rd_chk(MST_MEMORY_ACCESS_DATA, 8'h69, "control byte");
        $display("test memory done");
        // Channel A receive from PCM port 1 slot 3, transmit to highway slot 1
        pcm_mode_in = 2'd0;
        reg_wr(MST_XFER_RX_ADDR_A, 8'h0b);
        reg_wr(MST_XFER_RX_ADDR_B, 8'h89);
        reg_wr(MST_XFER_TX_ADDR_A, 8'h81);
        reg_wr(MST_XFER_DATA_A, 8'h96);
        u_mst_highway_model.run_frame(1'b0, 3'd1, 7'd3, 8'hc5, 1'b1, 3'd0, 7'd1, txb, txa);
        check8("highway tx byte", 8'h96, txb);
        check8("highway tx active", 8'hff, txa);
        rd_chk(MST_XFER_DATA_A, 8'hc5, "channel a rx");
        // Channel B receive from highway slot 5, channel A transmit to PCM port 1 slot 0
        reg_wr(MST_XFER_RX_ADDR_B, 8'h85);
        reg_wr(MST_XFER_TX_ADDR_A, 8'h02);
        u_mst_highway_model.run_frame(1'b1, 3'd0, 7'd5, 8'h3a, 1'b0, 3'd1, 7'd0, txb, txa);
        check8("pcm tx byte", 8'hc5, txb);
        check8("pcm tx active", 8'hff, txa);
        rd_chk(MST_XFER_DATA_B, 8'h3a, "channel b rx");
        $display("test transfer done");
        print_verdict();
    end
endmodule // tb_mem_access_sync_transfer
`default_nettype wire
